// ===== src/msair_map.svh
`ifndef MSAIR_MAP_SVH
`define MSAIR_MAP_SVH

// register addresses
`define MSAIR_A_STATE   16'h2271
`define MSAIR_A_MIXAMP  16'h2272
`define MSAIR_A_VGA     16'h2273
`define MSAIR_A_AVG     16'h2274
`define MSAIR_A_PKT     16'h2275
`define MSAIR_A_CFG     16'h2276
`define MSAIR_A_MASK    16'h2277
`define MSAIR_A_IDX     16'h2278
`define MSAIR_A_CONC    16'h227E
`define MSAIR_A_CTRL    16'h227F

// field positions
`define MSAIR_B_STLOCK  4
`define MSAIR_B_MIXLOCK 7
`define MSAIR_B_AMPLOCK 6
`define MSAIR_B_MIX     5
`define MSAIR_B_AMP     4
`define MSAIR_B_VGALOCK 7
`define MSAIR_B_FLUSH   3
`define MSAIR_B_ON      0
`define MSAIR_B_TRANSMIT_REQUEST_FLAG   1
`define MSAIR_B_RXEN    2
`define MSAIR_B_TEST    3

// reset values
`define MSAIR_RST_VGA   6'h2F
`define MSAIR_RST_CONC  4'hF

// modem state codes
`define MSAIR_C_IDLE    4'h0
`define MSAIR_C_DCCAL   4'h1
`define MSAIR_C_WSUP    4'h2
`define MSAIR_C_WLCK    4'h3
`define MSAIR_C_RDY     4'h4
`define MSAIR_C_TXSET   4'h5
`define MSAIR_C_TXPKT   4'h6
`define MSAIR_C_RXSET   4'h7
`define MSAIR_C_RXLIS   4'h8
`define MSAIR_C_RXPKT   4'h9
`define MSAIR_C_TEST    4'hB
`define MSAIR_C_GAP     4'hC
`define MSAIR_C_CLR     4'hD

// interrupt indices
`define MSAIR_I_UP      2'h0
`define MSAIR_I_TXD     2'h1
`define MSAIR_I_RXB     2'h2
`define MSAIR_I_RXD     2'h3

`endif

// ===== src/msair_pkg.sv
package msair_pkg;

    typedef enum logic [12:0] {
        st_idle         = 13'h0001,
        st_dc_calibrate = 13'h0002,
        st_wait_supply  = 13'h0004,
        st_wait_lock    = 13'h0008,
        st_ready        = 13'h0010,
        st_tx_settle    = 13'h0020,
        st_tx_packet    = 13'h0040,
        st_rx_settle    = 13'h0080,
        st_rx_listen    = 13'h0100,
        st_rx_packet    = 13'h0200,
        st_rf_test      = 13'h0400,
        st_test_gap     = 13'h0800,
        st_clear        = 13'h1000
    } msair_mode_e;

    typedef struct packed {
        logic       dc_cal_done;
        logic       supply_ok;
        logic       pll_lock;
        logic       tx_settled;
        logic       rx_settled;
        logic       pkt_start;
        logic       pkt_end;
        logic       tx_end;
        logic       fast_rate;
        logic       energy_valid;
        logic [7:0] energy;
    } msair_rf_s;

    typedef struct packed {
        logic       mixer;
        logic       amp;
        logic [5:0] vga;
    } msair_gain_s;

    typedef struct packed {
        logic low_power;
        logic dc_cal_en;
        logic pll_power;
        logic tx_en;
        logic pkt_tx;
        logic rx_en;
        logic pkt_rx;
    } msair_ctl_s;

    typedef struct packed {
        msair_mode_e        st;
        logic [3:0]         sw_st;
        logic               st_lock;
        logic               mix_lock;
        logic               amp_lock;
        logic               sw_mix;
        logic               sw_amp;
        logic               vga_lock;
        logic [5:0]         sw_vga;
        logic [2:0]         win;
        logic               modem_on;
        logic               tx_req;
        logic               rx_ena;
        logic               test_ena;
        logic [3:0]         mask;
        logic [3:0]         conc;
        logic               fast;
        logic               flush;
        logic [3:0]         pend;
        logic [3:0][1:0]    q;
        logic [2:0]         cnt;
        logic signed [14:0] acc;
        logic [6:0]         scnt;
        logic [7:0]         avg;
        logic [7:0]         pkt_e;
        logic [7:0]         rdata;
        logic               irq;
        msair_gain_s        gain;
        msair_ctl_s         ctl;
    } msair_state_s;

endpackage

// ===== src/msair_regs.sv
// What this block does
// - idle state: no packet traffic, minimum current; traffic only after ready
// - dc calibration runs, then synthesizer powers up by itself
// - wait supply stable, then lock; ready only with both
// - transmit settle state until transmitter settled, then send packet
// - receive settle state until receiver settled, then listen
// - listen watches for packets; packet state returns to listen when done
// - code 1010 reserved, 1011 rf test, 1100 next test packet gap
// - clear 1101 ends transmit, sets request flag, goes listen; 1110/1111 unused
// - mixer lock zero applies software mixer bit; one lets agc control
// - amp lock zero applies software amp bit; one lets agc control
// - gain bits read applied gain; forced value while lock is zero
// - vga lock zero applies software six-bit gain; one lets agc
// - vga field bits 6:1, three stages, resets to 101111
// - keep windowed average received energy, signed dBm
// - latch energy per received packet, hold until next packet
// - mask bits gate rx end, rx start, tx end, ready; reset zero
// - index bit 4 flags received packet rate at each rx end
// - simultaneous interrupts queued in order; index read pops head
// - writing zero to clear-all bit flushes the queue; resets to one
// - index bits 1:0 name presented interrupt 0..3; reset 00
// - active-low concurrent flags set on event, cleared by writing one
// - cleared state lock forces written state until lock set again
`timescale 1ns/10ps
`include "msair_map.svh"

module msair_regs
    import msair_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire msair_rf_s   RF_IN,
    input  wire msair_gain_s AGC_IN,
    output msair_gain_s      GAIN_OUT,
    output msair_ctl_s       CTRL_OUT,
    output logic             IRQ
);

////////////////////////////////////////////////////////////////////////////////

    function automatic logic [3:0] enc(input msair_mode_e m);
        case (m)
            st_idle:         enc = `MSAIR_C_IDLE;
            st_dc_calibrate: enc = `MSAIR_C_DCCAL;
            st_wait_supply:  enc = `MSAIR_C_WSUP;
            st_wait_lock:    enc = `MSAIR_C_WLCK;
            st_ready:        enc = `MSAIR_C_RDY;
            st_tx_settle:    enc = `MSAIR_C_TXSET;
            st_tx_packet:    enc = `MSAIR_C_TXPKT;
            st_rx_settle:    enc = `MSAIR_C_RXSET;
            st_rx_listen:    enc = `MSAIR_C_RXLIS;
            st_rx_packet:    enc = `MSAIR_C_RXPKT;
            st_rf_test:      enc = `MSAIR_C_TEST;
            st_test_gap:     enc = `MSAIR_C_GAP;
            st_clear:        enc = `MSAIR_C_CLR;
            default:         enc = `MSAIR_C_IDLE;
        endcase
    endfunction

    // unused codes force idle rather than an undefined state
    function automatic msair_mode_e dec(input logic [3:0] c);
        case (c)
            `MSAIR_C_IDLE:  dec = st_idle;
            `MSAIR_C_DCCAL: dec = st_dc_calibrate;
            `MSAIR_C_WSUP:  dec = st_wait_supply;
            `MSAIR_C_WLCK:  dec = st_wait_lock;
            `MSAIR_C_RDY:   dec = st_ready;
            `MSAIR_C_TXSET: dec = st_tx_settle;
            `MSAIR_C_TXPKT: dec = st_tx_packet;
            `MSAIR_C_RXSET: dec = st_rx_settle;
            `MSAIR_C_RXLIS: dec = st_rx_listen;
            `MSAIR_C_RXPKT: dec = st_rx_packet;
            `MSAIR_C_TEST:  dec = st_rf_test;
            `MSAIR_C_GAP:   dec = st_test_gap;
            `MSAIR_C_CLR:   dec = st_clear;
            default:        dec = st_idle;
        endcase
    endfunction

////////////////////////////////////////////////////////////////////////////////

    msair_state_s       s_r;
    msair_state_s       s_nxt;
    msair_mode_e        fsm;
    logic [3:0]         ev;
    logic [7:0]         rd;
    logic [6:0]         lim;
    logic signed [14:0] sum;
    logic               pop;
    logic               wr_idx;

    always_comb begin
        s_nxt  = s_r;
        fsm    = s_r.st;
        ev     = 4'h0;
        rd     = 8'h00;
        lim    = 7'((8'h01 << s_r.win) - 8'h01);
        // 15 bits hold 128 full-scale signed samples without overflow
        sum    = s_r.acc + {{7{RF_IN.energy[7]}}, RF_IN.energy};
        wr_idx = WR && (ADDR == `MSAIR_A_IDX);
        // reading an empty queue shows index 00 and changes nothing
        pop    = RD && (ADDR == `MSAIR_A_IDX) && (s_r.cnt != 3'h0);

        // register writes
        if (WR) begin
            case (ADDR)
                `MSAIR_A_STATE: begin
                    s_nxt.sw_st   = WDATA[3:0];
                    s_nxt.st_lock = WDATA[`MSAIR_B_STLOCK];
                end
                `MSAIR_A_MIXAMP: begin
                    s_nxt.mix_lock = WDATA[`MSAIR_B_MIXLOCK];
                    s_nxt.amp_lock = WDATA[`MSAIR_B_AMPLOCK];
                    s_nxt.sw_mix   = WDATA[`MSAIR_B_MIX];
                    s_nxt.sw_amp   = WDATA[`MSAIR_B_AMP];
                end
                `MSAIR_A_VGA: begin
                    s_nxt.vga_lock = WDATA[`MSAIR_B_VGALOCK];
                    s_nxt.sw_vga   = WDATA[6:1];
                end
                `MSAIR_A_CFG:  s_nxt.win  = WDATA[2:0];
                `MSAIR_A_MASK: s_nxt.mask = WDATA[3:0];
                // the flush itself is done below, after the pop
                `MSAIR_A_IDX:  s_nxt.flush = WDATA[`MSAIR_B_FLUSH];
                // writing one releases a flag, zero leaves it alone
                `MSAIR_A_CONC: begin
                    for (int i = 0; i < 4; i++) begin
                        if (WDATA[i]) begin
                            s_nxt.conc[i] = 1'b1;
                        end
                    end
                end
                `MSAIR_A_CTRL: begin
                    s_nxt.modem_on = WDATA[`MSAIR_B_ON];
                    s_nxt.tx_req   = WDATA[`MSAIR_B_TRANSMIT_REQUEST_FLAG];
                    s_nxt.rx_ena   = WDATA[`MSAIR_B_RXEN];
                    s_nxt.test_ena = WDATA[`MSAIR_B_TEST];
                end
                default: ;
            endcase
        end

        // modem sequencer; transmit request is active low
        case (s_r.st)
            st_idle: begin
                if (s_r.modem_on) begin
                    fsm = st_dc_calibrate;
                end
            end
            st_dc_calibrate: begin
                if (RF_IN.dc_cal_done) begin
                    fsm = st_wait_supply;
                end
            end
            st_wait_supply: begin
                if (RF_IN.supply_ok) begin
                    fsm = st_wait_lock;
                end
            end
            st_wait_lock: begin
                if (RF_IN.supply_ok && RF_IN.pll_lock) begin
                    fsm = st_ready;
                    ev[`MSAIR_I_UP] = 1'b1;
                end
            end
            // test mode first, then a transmit request, then receive
            st_ready: begin
                if (s_r.test_ena) begin
                    fsm = st_rf_test;
                end else if (!s_r.tx_req) begin
                    fsm = st_tx_settle;
                end else if (s_r.rx_ena) begin
                    fsm = st_rx_settle;
                end
            end
            st_tx_settle: begin
                if (RF_IN.tx_settled) begin
                    fsm = st_tx_packet;
                end
            end
            st_tx_packet: begin
                if (RF_IN.tx_end) begin
                    fsm = st_clear;
                    ev[`MSAIR_I_TXD] = 1'b1;
                end
            end
            st_rx_settle: begin
                if (RF_IN.rx_settled) begin
                    fsm = st_rx_listen;
                end
            end
            st_rx_listen: begin
                if (RF_IN.pkt_start) begin
                    fsm = st_rx_packet;
                    ev[`MSAIR_I_RXB] = 1'b1;
                end else if (!s_r.tx_req) begin
                    fsm = st_tx_settle;
                end
            end
            st_rx_packet: begin
                if (RF_IN.pkt_end) begin
                    fsm = st_rx_listen;
                    ev[`MSAIR_I_RXD] = 1'b1;
                end
            end
            st_rf_test: begin
                if (!s_r.test_ena) begin
                    fsm = st_ready;
                end else if (RF_IN.tx_end) begin
                    fsm = st_test_gap;
                end
            end
            st_test_gap: begin
                if (!s_r.test_ena) begin
                    fsm = st_ready;
                end else if (!s_r.tx_req) begin
                    fsm = st_rf_test;
                end
            end
            // one cycle in clear is enough to restore the request flag
            st_clear: begin
                fsm = st_rx_listen;
            end
            // a corrupt state code falls back to idle
            default: fsm = st_idle;
        endcase

        if (!s_r.modem_on) begin
            fsm = st_idle;
        end

        // forced state holds and raises no events
        if (!s_r.st_lock) begin
            fsm = dec(s_r.sw_st);
            ev  = 4'h0;
        end
        s_nxt.st = fsm;

        // hardware set beats a software write in the same cycle
        if (s_r.st == st_clear) begin
            s_nxt.tx_req = 1'b1;
        end

        // rate flag and packet energy are taken at receive end only,
        // so they hold until the next packet completes
        if (ev[`MSAIR_I_RXD]) begin
            s_nxt.fast  = RF_IN.fast_rate;
            s_nxt.pkt_e = s_r.avg;
        end

        // windowed energy average, 2**win samples
        if (RF_IN.energy_valid) begin
            if (s_r.scnt == lim) begin
                s_nxt.avg  = 8'(sum >>> s_r.win);
                s_nxt.acc  = 15'sh0000;
                s_nxt.scnt = 7'h00;
            end else begin
                s_nxt.acc  = sum;
                s_nxt.scnt = s_r.scnt + 7'h01;
            end
        end

        // pending queue: pop, then flush, then append new events
        if (pop) begin
            s_nxt.pend[s_r.q[0]] = 1'b0;
            for (int i = 0; i < 3; i++) begin
                s_nxt.q[i] = s_r.q[i+1];
            end
            s_nxt.q[3] = 2'h0;
            s_nxt.cnt  = s_r.cnt - 3'h1;
        end
        if (wr_idx && !WDATA[`MSAIR_B_FLUSH]) begin
            s_nxt.pend = 4'h0;
            s_nxt.q    = 8'h00;
            s_nxt.cnt  = 3'h0;
        end
        // a source already waiting is not queued twice, so depth 4 suffices
        for (int i = 0; i < 4; i++) begin
            if (ev[i] && s_r.mask[i]) begin
                s_nxt.conc[i] = 1'b0;
                if (!s_nxt.pend[i]) begin
                    s_nxt.q[s_nxt.cnt[1:0]] = 2'(i);
                    s_nxt.pend[i] = 1'b1;
                    s_nxt.cnt     = s_nxt.cnt + 3'h1;
                end
            end
        end
        // masked events never enter the queue, so a count is enough
        s_nxt.irq = (s_nxt.cnt != 3'h0);

        // gain selection
        s_nxt.gain.mixer = s_nxt.mix_lock ? AGC_IN.mixer : s_nxt.sw_mix;
        s_nxt.gain.amp   = s_nxt.amp_lock ? AGC_IN.amp : s_nxt.sw_amp;
        s_nxt.gain.vga   = s_nxt.vga_lock ? AGC_IN.vga : s_nxt.sw_vga;

        // rf controls follow the next state so they leave a flop
        s_nxt.ctl.low_power = (s_nxt.st == st_idle);
        s_nxt.ctl.dc_cal_en = (s_nxt.st == st_dc_calibrate);
        s_nxt.ctl.pll_power = (s_nxt.st != st_idle) &&
                              (s_nxt.st != st_dc_calibrate);
        // test mode keys the transmitter as well
        s_nxt.ctl.tx_en     = (s_nxt.st == st_tx_settle) ||
                              (s_nxt.st == st_tx_packet) ||
                              (s_nxt.st == st_rf_test) ||
                              (s_nxt.st == st_test_gap);
        s_nxt.ctl.pkt_tx    = (s_nxt.st == st_tx_packet) ||
                              (s_nxt.st == st_rf_test);
        s_nxt.ctl.rx_en     = (s_nxt.st == st_rx_settle) ||
                              (s_nxt.st == st_rx_listen) ||
                              (s_nxt.st == st_rx_packet);
        s_nxt.ctl.pkt_rx    = (s_nxt.st == st_rx_packet);

        // read mux, data shown the cycle after the strobe
        case (ADDR)
            `MSAIR_A_STATE:  rd = {3'h7, s_r.st_lock, enc(s_r.st)};
            `MSAIR_A_MIXAMP: rd = {s_r.mix_lock, s_r.amp_lock,
                                   s_r.gain.mixer, s_r.gain.amp,
                                   4'hF};
            `MSAIR_A_VGA:    rd = {s_r.vga_lock, s_r.gain.vga, 1'h1};
            `MSAIR_A_AVG:    rd = s_r.avg;
            `MSAIR_A_PKT:    rd = s_r.pkt_e;
            `MSAIR_A_CFG:    rd = {5'h00, s_r.win};
            `MSAIR_A_MASK:   rd = {4'hF, s_r.mask};
            `MSAIR_A_IDX:    rd = {3'h7, s_r.fast, s_r.flush, 1'h1,
                                   s_r.q[0]};
            `MSAIR_A_CONC:   rd = {3'h7, s_r.fast, s_r.conc};
            `MSAIR_A_CTRL:   rd = {4'h0, s_r.test_ena, s_r.rx_ena,
                                   s_r.tx_req, s_r.modem_on};
            default:         rd = 8'h00;
        endcase
        // idle read data is zero so several slaves can be ored together
        s_nxt.rdata = RD ? rd : 8'h00;

        // reset comes last so it overrides every update above
        if (!RST_N) begin
            s_nxt               = '0;
            s_nxt.st            = st_idle;
            s_nxt.st_lock       = 1'b1;
            s_nxt.mix_lock      = 1'b1;
            s_nxt.amp_lock      = 1'b1;
            s_nxt.sw_mix        = 1'b1;
            s_nxt.sw_amp        = 1'b1;
            s_nxt.vga_lock      = 1'b1;
            s_nxt.sw_vga        = `MSAIR_RST_VGA;
            s_nxt.tx_req        = 1'b1;
            s_nxt.conc          = `MSAIR_RST_CONC;
            s_nxt.fast          = 1'b1;
            s_nxt.flush         = 1'b1;
            s_nxt.gain.mixer    = 1'b1;
            s_nxt.gain.amp      = 1'b1;
            s_nxt.gain.vga      = `MSAIR_RST_VGA;
            s_nxt.ctl.low_power = 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        s_r <= s_nxt;
    end

////////////////////////////////////////////////////////////////////////////////

    assign RDATA    = s_r.rdata;
    assign GAIN_OUT = s_r.gain;
    assign CTRL_OUT = s_r.ctl;
    assign IRQ      = s_r.irq;

endmodule

// ===== test/msair_regs_checker.sv
`timescale 1ns/10ps
`include "msair_map.svh"

module msair_regs_checker
    import msair_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        RST_N,
    input wire logic [15:0] ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire msair_rf_s   RF_IN,
    input wire msair_gain_s AGC_IN,
    input wire msair_gain_s GAIN_OUT,
    input wire msair_ctl_s  CTRL_OUT,
    input wire logic        IRQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////////////////////////////////////
    a_rd_quiet: assert property (
        !RD |=> RDATA == 8'h00)
        else $error("read data driven outside read slot");
    a_gain_reset: assert property (
        $rose(RST_N) |-> GAIN_OUT == msair_gain_s'(8'hEF) && !IRQ)
        else $error("gain or irq wrong after reset");
    a_ctrl_idle: assert property (
        CTRL_OUT.low_power |-> !(CTRL_OUT.tx_en || CTRL_OUT.pkt_tx
            || CTRL_OUT.rx_en || CTRL_OUT.pkt_rx))
        else $error("traffic enabled in low power");
    // an irq rise always follows an input event by one edge
    a_irq_cause: assert property (
        $rose(IRQ) |-> $past(RF_IN.tx_end) || $past(RF_IN.pkt_start)
            || $past(RF_IN.pkt_end) || $past(RF_IN.pll_lock))
        else $error("irq rose without event");
    a_irq_drop: assert property (
        $fell(IRQ) && $past(RST_N) |-> $past(ADDR) == `MSAIR_A_IDX
            && ($past(RD) || $past(WR) && !$past(WDATA[3])))
        else $error("irq fell without pop or flush");
    a_idx_form: assert property (
        RD && ADDR == `MSAIR_A_IDX |=> RDATA[7:5] == 3'h7 && RDATA[2])
        else $error("index byte layout wrong");
    a_mask_form: assert property (
        RD && ADDR == `MSAIR_A_MASK |=> RDATA[7:4] == 4'hF)
        else $error("mask byte layout wrong");
    a_state_form: assert property (
        RD && ADDR == `MSAIR_A_STATE |=> RDATA[7:5] == 3'h7
            && RDATA[3:0] < 4'hE && RDATA[3:0] != 4'hA)
        else $error("state code unused or reserved");
    a_vga_form: assert property (
        RD && ADDR == `MSAIR_A_VGA |=> RDATA[0])
        else $error("vga low bit not one");
endmodule

bind msair_regs msair_regs_checker i_msair_regs_checker (
    .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .RF_IN(RF_IN), .AGC_IN(AGC_IN),
    .GAIN_OUT(GAIN_OUT), .CTRL_OUT(CTRL_OUT), .IRQ(IRQ)
);

// ===== test/tb.sv
`timescale 1ns/10ps
`include "msair_map.svh"

module tb
    import msair_pkg::*;
;
    localparam logic [17:0] P_RXS = 18'h01000;
    localparam logic [17:0] P_RXE = 18'h00800;
    localparam logic [17:0] P_TXE = 18'h00400;
    localparam logic [17:0] P_EV  = 18'h00100;
    logic        MCLK;
    logic        RST_N;
    logic [15:0] ADDR;
    logic [7:0]  WDATA;
    logic        WR;
    logic        RD;
    logic [7:0]  RDATA;
    msair_rf_s   RF_IN;
    msair_gain_s AGC_IN;
    msair_gain_s GAIN_OUT;
    msair_ctl_s  CTRL_OUT;
    logic        IRQ;
    int          n_fail;
    int          n_tests;
    integer      seed;
    logic [7:0]  b;
    logic [7:0]  e1;
    logic [7:0]  avg;
    logic [5:0]  v;
    logic [3:0]  fin [5];
    logic [3:0]  fout [5];

    msair_regs i_msair_regs (
        .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .RF_IN(RF_IN), .AGC_IN(AGC_IN),
        .GAIN_OUT(GAIN_OUT), .CTRL_OUT(CTRL_OUT), .IRQ(IRQ)
    );

    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] ex);
        n_tests++;
        if (got !== ex) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge MCLK);
    endtask

    task wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge MCLK);
        WR <= 1'b1;
        ADDR <= ad;
        WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask

    task rd(input logic [15:0] ad, input logic [7:0] ex);
        @(posedge MCLK);
        RD <= 1'b1;
        ADDR <= ad;
        @(posedge MCLK);
        RD <= 1'b0;
        #1;
        chk(RDATA, ex);
    endtask

    // hold each event one cycle; the pulse is only seen in its state
    task pls(input logic [17:0] mk);
        @(posedge MCLK);
        RF_IN <= msair_rf_s'(RF_IN | mk);
        @(posedge MCLK);
        RF_IN <= msair_rf_s'(RF_IN & ~mk);
        tick(2);
    endtask

    task irq_is(input logic ex);
        #1;
        chk({7'h00, IRQ}, {7'h00, ex});
    endtask

    function automatic logic [7:0] avg2(input logic [7:0] x,
                                        input logic [7:0] y);
        logic signed [8:0] s;
        s = $signed({x[7], x}) + $signed({y[7], y});
        return s[8:1];
    endfunction

    task summarize;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // the whole sequence needs about two hundred cycles
    initial begin
        #100000;
        n_fail++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h8b1ef568;
        n_fail = 0;
        n_tests = 0;
        RST_N = 1'b0;
        ADDR = 16'h0000;
        WDATA = 8'h00;
        WR = 1'b0;
        RD = 1'b0;
        RF_IN = '0;
        AGC_IN = msair_gain_s'(8'($random(seed)));
        fin = '{4'hB, 4'hC, 4'hD, 4'hA, 4'hE};
        fout = '{4'hB, 4'hC, 4'hD, 4'h0, 4'h0};
        tick(5);
        RST_N <= 1'b1;
        rd(`MSAIR_A_MASK, 8'hF0);
        rd(`MSAIR_A_IDX, 8'hFC);
        rd(`MSAIR_A_CONC, 8'hFF);
        rd(`MSAIR_A_STATE, 8'hF0);
        rd(`MSAIR_A_MIXAMP, {2'b11, AGC_IN.mixer, AGC_IN.amp, 4'hF});
        rd(`MSAIR_A_VGA, {1'b1, AGC_IN.vga, 1'b1});
        rd(16'h2279, 8'h00);
        wr(16'h2279, 8'hAA);
        rd(16'h2279, 8'h00);
        repeat (4) begin
            b = 8'($random(seed));
            v = 6'($random(seed));
            wr(`MSAIR_A_MIXAMP, {2'b00, b[1:0], 4'hF});
            wr(`MSAIR_A_VGA, {1'b0, v, 1'b1});
            rd(`MSAIR_A_MIXAMP, {2'b00, b[1:0], 4'hF});
            rd(`MSAIR_A_VGA, {1'b0, v, 1'b1});
            chk(GAIN_OUT, {b[1:0], v});
        end
        wr(`MSAIR_A_MIXAMP, 8'hFF);
        wr(`MSAIR_A_VGA, 8'hFF);
        AGC_IN <= msair_gain_s'(8'($random(seed)));
        tick(3);
        #1;
        chk(GAIN_OUT, AGC_IN);
        // bring-up, one transmit and one receive with all sources open
        wr(`MSAIR_A_MASK, 8'h0F);
        wr(`MSAIR_A_CTRL, 8'h03);
        rd(`MSAIR_A_STATE, 8'hF1);
        chk({1'b0, CTRL_OUT}, 8'h20);
        RF_IN.dc_cal_done <= 1'b1;
        rd(`MSAIR_A_STATE, 8'hF2);
        RF_IN.supply_ok <= 1'b1;
        rd(`MSAIR_A_STATE, 8'hF3);
        RF_IN.pll_lock <= 1'b1;
        rd(`MSAIR_A_STATE, 8'hF4);
        chk({1'b0, CTRL_OUT}, 8'h10);
        irq_is(1'b1);
        wr(`MSAIR_A_CTRL, 8'h01);
        rd(`MSAIR_A_STATE, 8'hF5);
        RF_IN.tx_settled <= 1'b1;
        rd(`MSAIR_A_STATE, 8'hF6);
        chk({1'b0, CTRL_OUT}, 8'h1C);
        pls(P_TXE);
        rd(`MSAIR_A_STATE, 8'hF8);
        rd(`MSAIR_A_CTRL, 8'h03);
        pls(P_RXS);
        rd(`MSAIR_A_STATE, 8'hF9);
        chk({1'b0, CTRL_OUT}, 8'h13);
        pls(P_RXE);
        rd(`MSAIR_A_STATE, 8'hF8);
        for (int i = 0; i < 4; i++) begin
            rd(`MSAIR_A_IDX, 8'hEC + i[7:0]);
        end
        irq_is(1'b0);
        rd(`MSAIR_A_CONC, 8'hE0);
        wr(`MSAIR_A_CONC, 8'h0F);
        rd(`MSAIR_A_CONC, 8'hEF);
        // two-sample window, then a packet with rx start masked
        wr(`MSAIR_A_CFG, 8'h01);
        e1 = 8'($random(seed));
        b = 8'($random(seed));
        avg = avg2(e1, b);
        RF_IN.energy <= e1;
        pls(P_EV);
        RF_IN.energy <= b;
        pls(P_EV);
        rd(`MSAIR_A_AVG, avg);
        wr(`MSAIR_A_AVG, 8'h55);
        rd(`MSAIR_A_AVG, avg);
        wr(`MSAIR_A_MASK, 8'h0B);
        RF_IN.fast_rate <= 1'b1;
        pls(P_RXS);
        irq_is(1'b0);
        pls(P_RXE);
        irq_is(1'b1);
        rd(`MSAIR_A_IDX, 8'hFF);
        rd(`MSAIR_A_PKT, avg);
        RF_IN.energy <= ~avg;
        pls(P_EV);
        pls(P_EV);
        rd(`MSAIR_A_PKT, avg);
        // flush with two entries queued
        wr(`MSAIR_A_MASK, 8'h0F);
        pls(P_RXS);
        pls(P_RXE);
        irq_is(1'b1);
        wr(`MSAIR_A_IDX, 8'h00);
        tick(2);
        irq_is(1'b0);
        rd(`MSAIR_A_IDX, 8'hF4);
        wr(`MSAIR_A_IDX, 8'h08);
        for (int i = 0; i < 5; i++) begin
            wr(`MSAIR_A_STATE, {4'hE, fin[i]});
            rd(`MSAIR_A_STATE, {4'hE, fout[i]});
        end
        chk({7'h00, CTRL_OUT.low_power}, 8'h01);
        // release the lock; the sequencer climbs to receive settle alone
        wr(`MSAIR_A_CTRL, 8'h07);
        wr(`MSAIR_A_STATE, 8'hF0);
        tick(6);
        rd(`MSAIR_A_STATE, 8'hF7);
        chk({1'b0, CTRL_OUT}, 8'h12);
        RF_IN.rx_settled <= 1'b1;
        rd(`MSAIR_A_STATE, 8'hF8);
        // a reset in mid-run returns the registers to their reset values
        RST_N <= 1'b0;
        tick(2);
        RST_N <= 1'b1;
        rd(`MSAIR_A_STATE, 8'hF0);
        rd(`MSAIR_A_IDX, 8'hFC);
        chk({1'b0, CTRL_OUT}, 8'h40);
        irq_is(1'b0);
        summarize();
    end
endmodule
